// >>> rtl/nvac_cfg.svh
// Register offsets, field positions and timing constants for the nonvolatile access control
// Operation
// - Address bit 8 only on largest variant
// - Address registers reset undefined; software loads first
// - Low address bit 7 reads zero on smallest
// - Data register feeds program, receives read
// - Control bits 7 and 6 read zero
// - Mode decode: atomic, erase, write, reserved
// - Mode writes ignored while programming
// - Reset clears mode unless programming
// - Ready interrupt level while idle and enabled
// - Master arm self-clears after four cycles
// - Program go needs live master arm
// - Program go held until operation completes
// - Program start stalls CPU two cycles
// - Read strobe fetches now, stalls four
// - Programming blocks reads and address changes
// - Reset does not abort running operation
`ifndef NVAC_CFG_SVH
`define NVAC_CFG_SVH
`define NVAC_OFF_CONTROL 6'h1C
`define NVAC_OFF_DATA 6'h1D
`define NVAC_OFF_ADDR_LOW 6'h1E
`define NVAC_OFF_ADDR_HIGH 6'h1F
`define NVAC_BIT_READ 0
`define NVAC_BIT_GO 1
`define NVAC_BIT_ARM 2
`define NVAC_BIT_RIE 3
`define NVAC_BIT_MODE_LO 4
`define NVAC_BIT_MODE_HI 5
`define NVAC_DATA_RESET 8'h00
`define NVAC_MODE_RESET 2'h0
`define NVAC_ARM_CYCLES 3'h4
`define NVAC_PROG_STALL 3'h2
`define NVAC_READ_STALL 3'h4
`define NVAC_CLK_MHZ 250
`define NVAC_T_ATOMIC_US 3400
`define NVAC_T_SPLIT_US 1800
`endif

// >>> rtl/nvac_pkg.sv
// Types shared by the nonvolatile access control files
package nvac_pkg;
    typedef enum logic [1:0] {NVAC_ATOMIC, NVAC_ERASE, NVAC_WRITE, NVAC_RSVD} nvac_mode_e;
    typedef enum logic [1:0] {NVAC_IDLE, NVAC_ERASING, NVAC_WRITING} nvac_state_e;
endpackage : nvac_pkg

// >>> rtl/nvac_mem.sv
// Byte storage array with registered read data
`timescale 1ns/1ps
module nvac_mem #(
    parameter int AW = 9
) (
    // Clock
    input wire logic clk,
    // Access
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem_r [0:(1<<AW)-1];

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem_r[addr] <= wdata;
        end
        rdata <= mem_r[addr];
    end
endmodule : nvac_mem

// >>> rtl/nvac_timer.sv
// Programming time down-counter
`timescale 1ns/1ps
module nvac_timer #(
    parameter int CW = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Control
    input wire logic load,
    input wire logic [CW-1:0] count,
    output logic done
);
    logic [CW-1:0] cnt_r;

    // Keeps counting through reset so a running operation ends normally
    always_ff @(posedge clk)
    begin
        if (load)
        begin
            cnt_r <= count;
        end
        else if (cnt_r != '0)
        begin
            cnt_r <= cnt_r - 1'b1;
        end
        else if (sys_rst)
        begin
            // Idle or unknown count is cleared; a running count is spared
            cnt_r <= '0;
        end
        done <= !load && (cnt_r == {{(CW-1){1'b0}}, 1'b1});
    end
endmodule : nvac_timer

// >>> rtl/nvac_top.sv
// Register-level control of the on-chip data nonvolatile memory
`timescale 1ns/1ps
`include "nvac_cfg.svh"
module nvac_top #(
    parameter int SIZE_BYTES = 512,
    parameter int T_ATOMIC_CYC = `NVAC_T_ATOMIC_US * `NVAC_CLK_MHZ,
    parameter int T_SPLIT_CYC = `NVAC_T_SPLIT_US * `NVAC_CLK_MHZ
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // I/O register port
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [5:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // CPU side
    input wire logic global_irq_enable,
    output logic cpu_stall,
    output logic nvm_ready_irq
);
    localparam int AW = 9;
    localparam int CW = 22;

    typedef struct packed {
        logic [7:0] addr_low;
        logic addr_bit8;
        logic [7:0] data;
        logic [1:0] mode;
        logic rie;
        logic arm;
        logic [2:0] arm_cnt;
        logic go;
        nvac_pkg::nvac_state_e st;
        logic [2:0] stall_cnt;
        logic rd_pend;
        logic [7:0] rdata;
        logic stall;
        logic irq;
    } nvac_s;

    nvac_s q_r;
    nvac_s q_nxt;

    logic mem_we;
    logic [AW-1:0] mem_addr;
    logic [7:0] mem_rdata;
    logic tmr_load;
    logic [CW-1:0] tmr_count;
    logic tmr_done;
    logic [AW-1:0] addr_full;

    function automatic logic [AW-1:0] nvac_mask(input logic [AW-1:0] a);
        logic [AW-1:0] m;
        m = a;
        if (SIZE_BYTES < 512)
        begin
            m[8] = 1'b0;
        end
        if (SIZE_BYTES < 256)
        begin
            m[7] = 1'b0;
        end
        return m;
    endfunction : nvac_mask

    assign addr_full = nvac_mask({q_r.addr_bit8, q_r.addr_low});

    nvac_mem #(
        .AW(AW)
    ) u_mem (
        .clk(clk),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(mem_we && q_r.st == nvac_pkg::NVAC_ERASING ? 8'hFF : q_r.data),
        .rdata(mem_rdata)
    );

    nvac_timer #(
        .CW(CW)
    ) u_tmr (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(tmr_load),
        .count(tmr_count),
        .done(tmr_done)
    );

    always_comb
    begin
        logic busy;
        logic start;
        nvac_pkg::nvac_mode_e md;
        busy = q_r.go;
        start = 1'b0;
        md = nvac_pkg::nvac_mode_e'(q_r.mode);
        q_nxt = q_r;
        mem_we = 1'b0;
        mem_addr = addr_full;
        tmr_load = 1'b0;
        tmr_count = '0;
        q_nxt.rd_pend = 1'b0;

        // Arm window counts down and self-clears
        if (q_r.arm_cnt != 3'h0)
        begin
            q_nxt.arm_cnt = q_r.arm_cnt - 3'h1;
            if (q_r.arm_cnt == 3'h1)
            begin
                q_nxt.arm = 1'b0;
            end
        end
        if (q_r.stall_cnt != 3'h0)
        begin
            q_nxt.stall_cnt = q_r.stall_cnt - 3'h1;
        end

        if (io_wr && !sys_rst)
        begin
            if (io_addr == `NVAC_OFF_CONTROL)
            begin
                if (!busy)
                begin
                    q_nxt.mode = io_wdata[`NVAC_BIT_MODE_HI:`NVAC_BIT_MODE_LO];
                end
                q_nxt.rie = io_wdata[`NVAC_BIT_RIE];
                if (io_wdata[`NVAC_BIT_ARM] && !q_r.arm)
                begin
                    q_nxt.arm = 1'b1;
                    q_nxt.arm_cnt = `NVAC_ARM_CYCLES;
                end
                // Go counts only with a live arm and a non-reserved mode
                if (io_wdata[`NVAC_BIT_GO] && q_r.arm && !busy
                    && md != nvac_pkg::NVAC_RSVD)
                begin
                    start = 1'b1;
                end
                if (io_wdata[`NVAC_BIT_READ] && !busy)
                begin
                    q_nxt.rd_pend = 1'b1;
                    q_nxt.stall_cnt = `NVAC_READ_STALL;
                end
            end
            else if (io_addr == `NVAC_OFF_DATA)
            begin
                q_nxt.data = io_wdata;
            end
            else if (io_addr == `NVAC_OFF_ADDR_LOW)
            begin
                if (!busy)
                begin
                    q_nxt.addr_low = io_wdata;
                end
            end
            else if (io_addr == `NVAC_OFF_ADDR_HIGH)
            begin
                if (!busy)
                begin
                    q_nxt.addr_bit8 = io_wdata[0];
                end
            end
        end

        // Registered array output arrives one cycle after the strobe
        if (q_r.rd_pend)
        begin
            q_nxt.data = mem_rdata;
        end

        if (start)
        begin
            q_nxt.go = 1'b1;
            q_nxt.arm = 1'b0;
            q_nxt.arm_cnt = 3'h0;
            q_nxt.stall_cnt = `NVAC_PROG_STALL;
            tmr_load = 1'b1;
            if (md == nvac_pkg::NVAC_ATOMIC)
            begin
                tmr_count = CW'(T_ATOMIC_CYC);
                // Erase and write of one byte land as a single commit
                q_nxt.st = nvac_pkg::NVAC_WRITING;
            end
            else
            begin
                tmr_count = CW'(T_SPLIT_CYC);
                q_nxt.st = md == nvac_pkg::NVAC_ERASE ? nvac_pkg::NVAC_ERASING
                                                      : nvac_pkg::NVAC_WRITING;
            end
        end

        // Completion commits the byte in one write; erase leaves all ones
        // Mode may change once go falls, so nothing after this reads it
        if (tmr_done && q_r.go)
        begin
            mem_we = 1'b1;
            q_nxt.st = nvac_pkg::NVAC_IDLE;
            q_nxt.go = 1'b0;
        end

        // Reset spares a running operation's timer and mode but clears the data byte it commits
        if (sys_rst)
        begin
            q_nxt.rie = 1'b0;
            q_nxt.arm = 1'b0;
            q_nxt.arm_cnt = 3'h0;
            q_nxt.data = `NVAC_DATA_RESET;
            q_nxt.stall_cnt = 3'h0;
            q_nxt.rd_pend = 1'b0;
            // Unknown busy at power-up takes the else branch and idles
            if (q_r.go)
            begin
                q_nxt.mode = q_r.mode;
            end
            else
            begin
                q_nxt.go = 1'b0;
                q_nxt.st = nvac_pkg::NVAC_IDLE;
                q_nxt.mode = `NVAC_MODE_RESET;
            end
        end

        q_nxt.stall = q_nxt.stall_cnt != 3'h0;
        q_nxt.irq = q_nxt.rie && global_irq_enable && !q_nxt.go;

        q_nxt.rdata = 8'h00;
        if (io_rd)
        begin
            if (io_addr == `NVAC_OFF_CONTROL)
            begin
                q_nxt.rdata = {2'b00, q_nxt.mode, q_nxt.rie, q_nxt.arm, q_nxt.go,
                               1'b0};
            end
            else if (io_addr == `NVAC_OFF_DATA)
            begin
                q_nxt.rdata = q_nxt.data;
            end
            else if (io_addr == `NVAC_OFF_ADDR_LOW)
            begin
                q_nxt.rdata = SIZE_BYTES < 256 ? {1'b0, q_nxt.addr_low[6:0]}
                                               : q_nxt.addr_low;
            end
            else if (io_addr == `NVAC_OFF_ADDR_HIGH)
            begin
                q_nxt.rdata = {7'h00, SIZE_BYTES >= 512 && q_nxt.addr_bit8};
            end
        end
    end

    // Address registers are left alone by reset: software must load them
    always_ff @(posedge clk)
    begin
        q_r <= q_nxt;
    end

    assign io_rdata = q_r.rdata;
    assign cpu_stall = q_r.stall;
    assign nvm_ready_irq = q_r.irq;

    property arm_clears_p;
        @(posedge clk) disable iff (sys_rst)
        $rose(q_r.arm) |-> ##4 !q_r.arm;
    endproperty
    arm_self_clear_a: assert property (arm_clears_p)
        else $error("arm bit did not clear after four cycles");

    sequence go_start_s;
        !q_r.go ##1 q_r.go;
    endsequence
    prog_stall_two_a: assert property (@(posedge clk) disable iff (sys_rst)
        go_start_s |-> cpu_stall ##1 cpu_stall ##1 !cpu_stall)
        else $error("program start stall length wrong");

    mode_hold_busy_a: assert property (@(posedge clk)
        q_r.go && q_nxt.go |=> $stable(q_r.mode))
        else $error("mode changed while programming");

    addr_hold_busy_a: assert property (@(posedge clk) disable iff (sys_rst)
        q_r.go |=> $stable(q_r.addr_low) && $stable(q_r.addr_bit8))
        else $error("address changed while programming");

    irq_level_a: assert property (@(posedge clk) disable iff (sys_rst)
        nvm_ready_irq |-> !q_r.go)
        else $error("ready interrupt while busy");

    go_needs_arm_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(q_r.go) |-> $past(q_r.arm))
        else $error("program started without arm");

    rsvd_no_start_a: assert property (@(posedge clk) disable iff (sys_rst)
        !q_r.go && q_r.mode == 2'h3 |=> !q_r.go)
        else $error("reserved mode started an operation");

    ctrl_top_zero_a: assert property (@(posedge clk)
        $past(io_rd) && $past(io_addr) == `NVAC_OFF_CONTROL
        |-> io_rdata[7:6] == 2'b00)
        else $error("control reserved bits nonzero");

    sequence rd_start_s;
        !q_r.rd_pend ##1 q_r.rd_pend;
    endsequence
    read_stall_four_a: assert property (@(posedge clk) disable iff (sys_rst)
        rd_start_s |-> cpu_stall [*4] ##1 !cpu_stall)
        else $error("read strobe stall length wrong");

    read_data_load_a: assert property (@(posedge clk) disable iff (sys_rst)
        q_r.rd_pend |=> q_r.data == $past(mem_rdata))
        else $error("read strobe did not load the data register");

    read_refused_busy_a: assert property (@(posedge clk) disable iff (sys_rst)
        q_r.go |=> !q_r.rd_pend)
        else $error("read accepted while programming");

    go_clears_done_a: assert property (@(posedge clk) disable iff (sys_rst)
        q_r.go && tmr_done |=> !q_r.go)
        else $error("program bit not cleared at completion");

    mode_reset_a: assert property (@(posedge clk)
        sys_rst && !q_r.go |=> q_r.mode == `NVAC_MODE_RESET)
        else $error("mode not cleared by reset while idle");

    irq_ready_a: assert property (@(posedge clk) disable iff (sys_rst)
        !io_wr && q_r.rie && !q_r.go && global_irq_enable |=> nvm_ready_irq)
        else $error("ready interrupt missing while idle and enabled");

    arm_on_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        io_wr && io_addr == `NVAC_OFF_CONTROL && io_wdata[`NVAC_BIT_ARM] && !q_r.arm
        |=> q_r.arm)
        else $error("arm write did not set the arm bit");

    go_starts_a: assert property (@(posedge clk) disable iff (sys_rst)
        io_wr && io_addr == `NVAC_OFF_CONTROL && io_wdata[`NVAC_BIT_GO] && q_r.arm
        && !q_r.go && q_r.mode != 2'h3 |=> q_r.go)
        else $error("armed program write did not start");

    data_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        io_wr && io_addr == `NVAC_OFF_DATA && !q_r.rd_pend
        |=> q_r.data == $past(io_wdata))
        else $error("data register write lost");

    addr_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        io_wr && io_addr == `NVAC_OFF_ADDR_LOW && !q_r.go
        |=> q_r.addr_low == $past(io_wdata))
        else $error("address write lost while idle");
endmodule : nvac_top

// >>> testbench/eeprom_access_control_bench.sv
// Self-checking bench for the nonvolatile access control block
`timescale 1ns/1ps
`include "nvac_cfg.svh"
module eeprom_access_control_bench;
    // Short programming times keep the run brief
    localparam int TA = 20;
    localparam int TS = 10;
    localparam logic [5:0] CTL = `NVAC_OFF_CONTROL;
    localparam logic [5:0] DAT = `NVAC_OFF_DATA;
    localparam logic [5:0] ALO = `NVAC_OFF_ADDR_LOW;
    localparam logic [5:0] AHI = `NVAC_OFF_ADDR_HIGH;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [5:0] io_addr = 6'h00;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] io_rdata;
    logic global_irq_enable = 1'b1;
    logic cpu_stall;
    logic nvm_ready_irq;
    int n_errors = 0;
    int checked = 0;
    int stall_cnt = 0;
    int cycles = 0;
    int n;
    logic [7:0] v;
    logic [1:0] modes [3] = '{2'h0, 2'h1, 2'h2};
    logic [7:0] wdat [3] = '{8'hC3, 8'h00, 8'h3C};
    logic [7:0] stored [3] = '{8'hC3, 8'hFF, 8'h3C};
    int ptime [3] = '{TA, TS, TS};

    nvac_top #(.SIZE_BYTES(512), .T_ATOMIC_CYC(TA), .T_SPLIT_CYC(TS)) nvac_top_i (
        .clk(clk),
        .sys_rst(sys_rst),
        .io_wr(io_wr),
        .io_rd(io_rd),
        .io_addr(io_addr),
        .io_wdata(io_wdata),
        .io_rdata(io_rdata),
        .global_irq_enable(global_irq_enable),
        .cpu_stall(cpu_stall),
        .nvm_ready_irq(nvm_ready_irq)
    );

    always #2 clk = ~clk;

    // Old value is sampled at the edge, so each count is one stalled cycle
    always @(posedge clk)
    begin
        cycles++;
        if (cpu_stall === 1'b1)
            stall_cnt++;
        if (cycles == 3000)
        begin
            n_errors++;
            stop_test();
        end
    end

    task stop_test();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // Extra idle cycle so a strobe never rises in the step where it fell
    task wr(input logic [5:0] a, input logic [7:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
        @(negedge clk);
    endtask : wr

    task rd(input logic [5:0] a, output logic [7:0] d);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge clk);
        io_rd = 1'b0;
        d = io_rdata;
        @(negedge clk);
    endtask : rd

    function automatic logic [7:0] ctl(input logic [1:0] m, input logic [2:0] b);
        return {2'h0, m, 1'b1, b};
    endfunction : ctl

    task prog(input logic [1:0] m);
        wr(CTL, ctl(m, 3'h4));
        stall_cnt = 0;
        wr(CTL, ctl(m, 3'h6));
    endtask : prog

    task wait_ready(output int c);
        c = 0;
        while (nvm_ready_irq !== 1'b1 && c < 100)
        begin
            @(negedge clk);
            c++;
        end
    endtask : wait_ready

    task fetch(output logic [7:0] d);
        wr(DAT, 8'h00);
        stall_cnt = 0;
        wr(CTL, ctl(2'h0, 3'h1));
        repeat (4) @(negedge clk);
        rd(DAT, d);
    endtask : fetch

    initial
    begin
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        rd(CTL, v);
        chk(v & 8'hFD, 8'h00, "control after reset");
        rd(DAT, v);
        chk(v, `NVAC_DATA_RESET, "data after reset");
        wr(AHI, 8'hFF);
        wr(ALO, 8'hAB);
        rd(AHI, v);
        chk(v, 8'h01, "address high");
        rd(ALO, v);
        chk(v, 8'hAB, "address low");
        $display("test registers done");

        wr(DAT, 8'h5A);
        prog(2'h0);
        repeat (4) @(negedge clk);
        chk(8'(stall_cnt), 8'h02, "program stall");
        chk(8'(nvm_ready_irq), 8'h00, "irq while busy");
        wr(ALO, 8'h11);
        wr(CTL, ctl(2'h3, 3'h1));
        rd(CTL, v);
        chk(v & 8'h3A, 8'h0A, "mode held, go set");
        rd(ALO, v);
        chk(v, 8'hAB, "address locked");
        rd(DAT, v);
        chk(v, 8'h5A, "read refused");
        wait_ready(n);
        fetch(v);
        chk(v, 8'h5A, "atomic data");
        chk(8'(stall_cnt), 8'h04, "read stall");
        $display("test busy_lock done");

        for (int i = 0; i < 3; i++)
        begin
            wr(DAT, wdat[i]);
            prog(modes[i]);
            wait_ready(n);
            chk(8'(n >= ptime[i] - 3 && n <= ptime[i] + 3), 8'h01, "busy time");
            fetch(v);
            chk(v, stored[i], "mode result");
        end
        $display("test modes done");

        wr(CTL, ctl(2'h0, 3'h2));
        rd(CTL, v);
        chk(v & 8'h06, 8'h00, "go without arm");
        wr(CTL, ctl(2'h0, 3'h4));
        rd(CTL, v);
        chk(v & 8'h04, 8'h04, "arm set");
        repeat (4) @(negedge clk);
        wr(CTL, ctl(2'h0, 3'h2));
        rd(CTL, v);
        chk(v & 8'h06, 8'h00, "arm expired");
        prog(2'h3);
        rd(CTL, v);
        chk(v & 8'h02, 8'h00, "reserved mode");
        $display("test arming done");

        prog(2'h1);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        rd(CTL, v);
        chk(v & 8'h3A, 8'h12, "reset while busy");
        chk(8'(nvm_ready_irq), 8'h00, "irq enable reset");
        repeat (TS) @(negedge clk);
        rd(CTL, v);
        chk(v & 8'h32, 8'h10, "operation completed");
        wr(CTL, 8'h08);
        chk(8'(nvm_ready_irq), 8'h01, "irq ready");
        global_irq_enable = 1'b0;
        repeat (2) @(negedge clk);
        chk(8'(nvm_ready_irq), 8'h00, "irq global off");
        global_irq_enable = 1'b1;
        $display("test reset_irq done");
        stop_test();
    end
endmodule : eeprom_access_control_bench
